/* File: src/paged_i2c_target_port.sv */
`timescale 1ns/1ps

// ==========================================================
// Word buffer between the bus side and the register side
module sync_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      if (p == AW'(DEPTH - 1)) begin
         return '0;
      end
      return AW'(p + 1'b1);
   endfunction

   assign in_ready_o = (count_q != (AW + 1)'(DEPTH));
   assign out_valid_o = (count_q != '0);
   assign out_data_o = mem_q[rd_ptr_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= next_ptr(wr_ptr_q);
         end
         if (pop) begin
            rd_ptr_q <= next_ptr(rd_ptr_q);
         end
         if (push && !pop) begin
            count_q <= (AW + 1)'(count_q + 1'b1);
         end else if (pop && !push) begin
            count_q <= (AW + 1)'(count_q - 1'b1);
         end
      end
   end
endmodule

// ==========================================================
// Two-wire target port
module paged_i2c_target_port #(
   parameter int unsigned TIMEOUT_CYCLES = i2c_target_pkg::TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Strap pins
   input wire logic addr_strap_low_i,
   input wire logic addr_strap_high_i,
   input wire logic proto_sel_i,
   // Register side
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output i2c_target_pkg::wr_word_t wr_word_o,
   output i2c_target_pkg::reg_loc_t rd_loc_o,
   input wire logic [15:0] rd_data_i,
   // Status
   output logic i2c_mode_o,
   output logic [15:0] page_o,
   output logic busy_o
);
   i2c_target_pkg::bus_state_t state_q;
   i2c_target_pkg::wr_idx_t widx_q;
   i2c_target_pkg::reg_loc_t rd_loc_q;
   i2c_target_pkg::wr_word_t fifo_in;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] filt_q;
   logic [3:0] prev_q;
   logic [i2c_target_pkg::FILT_W-1:0] fcnt_q [i2c_target_pkg::NUM_LINES];
   logic [1:0] proto_sync_q;
   logic [i2c_target_pkg::MODE_W-1:0] mode_cnt_q;
   logic mode_done_q;
   logic i2c_mode_q;
   logic [i2c_target_pkg::TOUT_W-1:0] tcnt_q [2];
   logic [1:0] strap_pre_q;
   logic [1:0] strap_start_q;
   logic strap_wait_q;
   logic [3:0] strap_sel_q;
   logic [7:0] shift_q;
   logic [3:0] bitcnt_q;
   logic oe_q;
   logic rw_q;
   logic mack_q;
   logic busy_q;
   logic [6:0] ptr_q;
   logic block_q;
   logic [7:0] hi_q;
   logic [15:0] word_q;
   logic tx_lo_q;
   logic [15:0] page_q;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic timeout;
   logic rx_byte_done;
   logic word_done;
   logic is_page;
   logic fifo_ready;
   logic rx_ack;
   logic tx_load;
   logic [15:0] rd_word;
   logic [7:0] tx_next;

   // ==========================================================
   // Helpers
   function automatic logic [1:0] decode_strap(input logic pre, input logic at_start, input logic at_fall);
      if (!pre) begin
         return i2c_target_pkg::STRAP_LOW;
      end else if (!at_start) begin
         return i2c_target_pkg::STRAP_SDA;
      end else if (!at_fall) begin
         return i2c_target_pkg::STRAP_SCL;
      end
      return i2c_target_pkg::STRAP_HIGH;
   endfunction

   function automatic i2c_target_pkg::reg_loc_t make_loc(input logic [6:0] offs, input logic [15:0] page);
      i2c_target_pkg::reg_loc_t loc;
      loc.offset = offs;
      loc.global_win = (offs <= i2c_target_pkg::GLOBAL_LAST);
      loc.page = loc.global_win ? i2c_target_pkg::GLOBAL_PAGE : page[4:0];
      return loc;
   endfunction

   // ==========================================================
   // Pin synchronisers and spike filters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= i2c_target_pkg::LINE_RESET;
         sync2_q <= i2c_target_pkg::LINE_RESET;
         proto_sync_q <= '0;
      end else begin
         sync1_q <= {addr_strap_high_i, addr_strap_low_i, sda_i, scl_i};
         sync2_q <= sync1_q;
         proto_sync_q <= {proto_sync_q[0], proto_sel_i};
      end
   end

   // Straps pass the same filter so they stay aligned with SDA and SCL
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         filt_q <= i2c_target_pkg::LINE_RESET;
         prev_q <= i2c_target_pkg::LINE_RESET;
         for (int i = 0; i < i2c_target_pkg::NUM_LINES; i++) begin
            fcnt_q[i] <= '0;
         end
      end else begin
         prev_q <= filt_q;
         for (int i = 0; i < i2c_target_pkg::NUM_LINES; i++) begin
            if (sync2_q[i] != filt_q[i]) begin
               if (fcnt_q[i] == i2c_target_pkg::FILT_W'(i2c_target_pkg::FILT_CYC - 1)) begin
                  filt_q[i] <= sync2_q[i];
                  fcnt_q[i] <= '0;
               end else begin
                  fcnt_q[i] <= i2c_target_pkg::FILT_W'(fcnt_q[i] + 1'b1);
               end
            end else begin
               fcnt_q[i] <= '0;
            end
         end
      end
   end

   assign scl = filt_q[i2c_target_pkg::LINE_SCL];
   assign sda = filt_q[i2c_target_pkg::LINE_SDA];
   assign scl_rise = scl && !prev_q[i2c_target_pkg::LINE_SCL];
   assign scl_fall = !scl && prev_q[i2c_target_pkg::LINE_SCL];
   // SDA moving while SCL stays high
   assign start_ev = scl && prev_q[i2c_target_pkg::LINE_SCL] && prev_q[i2c_target_pkg::LINE_SDA] && !sda;
   assign stop_ev = scl && prev_q[i2c_target_pkg::LINE_SCL] && !prev_q[i2c_target_pkg::LINE_SDA] && sda;

   // ==========================================================
   // Protocol choice at start-up
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_cnt_q <= '0;
         mode_done_q <= 1'b0;
         i2c_mode_q <= 1'b0;
      end else if (!mode_done_q) begin
         if (mode_cnt_q == i2c_target_pkg::MODE_W'(i2c_target_pkg::MODE_WAIT_CYC - 1)) begin
            i2c_mode_q <= (proto_sync_q[1] == i2c_target_pkg::PROTO_I2C);
            mode_done_q <= 1'b1;
         end else begin
            mode_cnt_q <= i2c_target_pkg::MODE_W'(mode_cnt_q + 1'b1);
         end
      end
   end

   // ==========================================================
   // Stuck-low timeout, one counter each for SCL and SDA
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tcnt_q[0] <= '0;
         tcnt_q[1] <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (state_q == i2c_target_pkg::ST_IDLE || filt_q[i] || timeout) begin
               tcnt_q[i] <= '0;
            end else begin
               tcnt_q[i] <= i2c_target_pkg::TOUT_W'(tcnt_q[i] + 1'b1);
            end
         end
      end
   end

   assign timeout = (tcnt_q[0] == i2c_target_pkg::TOUT_W'(TIMEOUT_CYCLES - 1)) ||
                    (tcnt_q[1] == i2c_target_pkg::TOUT_W'(TIMEOUT_CYCLES - 1));

   // ==========================================================
   // Address straps: level before START, at START, at first SCL fall
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_pre_q <= '0;
         strap_start_q <= '0;
         strap_wait_q <= 1'b0;
         strap_sel_q <= '0;
      end else if (start_ev) begin
         strap_pre_q <= prev_q[3:2];
         strap_start_q <= filt_q[3:2];
         strap_wait_q <= 1'b1;
      end else if (strap_wait_q && scl_fall) begin
         strap_sel_q <= {decode_strap(strap_pre_q[1], strap_start_q[1], filt_q[3]),
                         decode_strap(strap_pre_q[0], strap_start_q[0], filt_q[2])};
         strap_wait_q <= 1'b0;
      end
   end

   // ==========================================================
   // Byte-level decisions
   assign rx_byte_done = (state_q == i2c_target_pkg::ST_RX) && scl_fall && (bitcnt_q == i2c_target_pkg::BYTE_BITS);
   assign word_done = rx_byte_done && (widx_q == i2c_target_pkg::WIDX_LO);
   assign is_page = (ptr_q == i2c_target_pkg::PAGE_SEL_ADDR);
   // Full buffer refuses the word with a not-acknowledge
   assign rx_ack = !(word_done && !is_page && !fifo_ready);
   assign rd_word = is_page ? page_q : rd_data_i;
   assign tx_next = tx_lo_q ? word_q[7:0] : rd_word[15:8];
   assign tx_load = scl_fall && (((state_q == i2c_target_pkg::ST_ADDR_ACK) && rw_q) ||
                                 ((state_q == i2c_target_pkg::ST_TX_ACK) && mack_q));
   assign fifo_in.loc = make_loc(ptr_q, page_q);
   assign fifo_in.data = {hi_q, shift_q};

   // ==========================================================
   // Bus state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= i2c_target_pkg::ST_IDLE;
         shift_q <= '0;
         bitcnt_q <= '0;
         oe_q <= 1'b0;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
      end else if (!i2c_mode_q || timeout) begin
         state_q <= i2c_target_pkg::ST_IDLE;
         oe_q <= 1'b0;
      end else if (start_ev) begin
         state_q <= i2c_target_pkg::ST_ADDR;
         bitcnt_q <= '0;
         oe_q <= 1'b0;
      end else if (stop_ev) begin
         state_q <= i2c_target_pkg::ST_IDLE;
         oe_q <= 1'b0;
      end else begin
         unique case (state_q)
            i2c_target_pkg::ST_IDLE, i2c_target_pkg::ST_IGNORE: begin
               oe_q <= 1'b0;
            end
            i2c_target_pkg::ST_ADDR, i2c_target_pkg::ST_RX: begin
               if (scl_rise && bitcnt_q != i2c_target_pkg::BYTE_BITS) begin
                  shift_q <= {shift_q[6:0], sda};
                  bitcnt_q <= 4'(bitcnt_q + 1'b1);
               end else if (scl_fall && bitcnt_q == i2c_target_pkg::BYTE_BITS) begin
                  bitcnt_q <= '0;
                  if (state_q == i2c_target_pkg::ST_RX) begin
                     state_q <= i2c_target_pkg::ST_RX_ACK;
                     oe_q <= rx_ack;
                  end else if (shift_q[7:1] == {i2c_target_pkg::TARGET_UPPER, strap_sel_q}) begin
                     state_q <= i2c_target_pkg::ST_ADDR_ACK;
                     rw_q <= shift_q[0];
                     oe_q <= 1'b1;
                  end else begin
                     state_q <= i2c_target_pkg::ST_IGNORE;
                  end
               end
            end
            i2c_target_pkg::ST_ADDR_ACK, i2c_target_pkg::ST_RX_ACK: begin
               // Held from fall to fall, covering the whole high phase
               if (tx_load) begin
                  state_q <= i2c_target_pkg::ST_TX;
                  shift_q <= tx_next;
                  oe_q <= !tx_next[7];
                  bitcnt_q <= 4'h1;
               end else if (scl_fall) begin
                  state_q <= i2c_target_pkg::ST_RX;
                  oe_q <= 1'b0;
                  bitcnt_q <= '0;
               end
            end
            i2c_target_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (bitcnt_q == i2c_target_pkg::BYTE_BITS) begin
                     state_q <= i2c_target_pkg::ST_TX_ACK;
                     oe_q <= 1'b0;
                  end else begin
                     oe_q <= !shift_q[6];
                     shift_q <= {shift_q[6:0], 1'b0};
                     bitcnt_q <= 4'(bitcnt_q + 1'b1);
                  end
               end
            end
            i2c_target_pkg::ST_TX_ACK: begin
               if (scl_rise) begin
                  mack_q <= !sda;
               end else if (tx_load) begin
                  state_q <= i2c_target_pkg::ST_TX;
                  shift_q <= tx_next;
                  oe_q <= !tx_next[7];
                  bitcnt_q <= 4'h1;
               end else if (scl_fall) begin
                  state_q <= i2c_target_pkg::ST_IGNORE;
               end
            end
            default: begin
               state_q <= i2c_target_pkg::ST_IDLE;
               oe_q <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Pointer, page and data words
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         widx_q <= i2c_target_pkg::WIDX_REG;
         ptr_q <= '0;
         block_q <= 1'b0;
         hi_q <= '0;
         word_q <= '0;
         tx_lo_q <= 1'b0;
         page_q <= i2c_target_pkg::PAGE_RESET;
      end else if (start_ev) begin
         widx_q <= i2c_target_pkg::WIDX_REG;
         tx_lo_q <= 1'b0;
      end else if (rx_byte_done) begin
         unique case (widx_q)
            i2c_target_pkg::WIDX_REG: begin
               block_q <= shift_q[7];
               ptr_q <= shift_q[6:0];
               widx_q <= i2c_target_pkg::WIDX_HI;
            end
            i2c_target_pkg::WIDX_HI: begin
               hi_q <= shift_q;
               widx_q <= i2c_target_pkg::WIDX_LO;
            end
            i2c_target_pkg::WIDX_LO: begin
               if (is_page) begin
                  page_q <= {hi_q, shift_q};
               end
               if (block_q && ptr_q != i2c_target_pkg::LAST_ADDR) begin
                  ptr_q <= 7'(ptr_q + 1'b1);
               end
               widx_q <= i2c_target_pkg::WIDX_HI;
            end
            default: begin
               widx_q <= i2c_target_pkg::WIDX_REG;
            end
         endcase
      end else if (tx_load) begin
         if (!tx_lo_q) begin
            word_q <= rd_word;
         end
         tx_lo_q <= !tx_lo_q;
      end else if ((state_q == i2c_target_pkg::ST_TX_ACK) && scl_rise && !sda && !tx_lo_q) begin
         if (block_q && ptr_q != i2c_target_pkg::LAST_ADDR) begin
            ptr_q <= 7'(ptr_q + 1'b1);
         end
      end
   end

   // ==========================================================
   // Register-side buffer and outputs
   sync_fifo #(
      .WIDTH($bits(i2c_target_pkg::wr_word_t)),
      .DEPTH(i2c_target_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(word_done && !is_page),
      .in_ready_o(fifo_ready),
      .in_data_i(fifo_in),
      .out_valid_o(wr_valid_o),
      .out_ready_i(wr_ready_i),
      .out_data_o(wr_word_o)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_loc_q <= '0;
         busy_q <= 1'b0;
      end else begin
         rd_loc_q <= make_loc(ptr_q, page_q);
         busy_q <= (state_q != i2c_target_pkg::ST_IDLE);
      end
   end

   // Only SDA is ever pulled low; SCL is input only
   assign sda_o = 1'b0;
   assign sda_oe_o = oe_q;
   assign rd_loc_o = rd_loc_q;
   assign i2c_mode_o = i2c_mode_q;
   assign page_o = page_q;
   assign busy_o = busy_q;
endmodule

/* File: src/i2c_target_pkg.sv */
package i2c_target_pkg;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned TIMEOUT_MS = 25;
   localparam int unsigned TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
   localparam int unsigned TOUT_W = 20;
   localparam int unsigned SPIKE_NS = 50;
   localparam int unsigned FILT_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FILT_W = 3;
   localparam int unsigned MODE_WAIT_CYC = 4;
   localparam int unsigned MODE_W = 3;

   // ==========================================================
   // Register map and addressing
   localparam logic [6:0] PAGE_SEL_ADDR = 7'h01;
   localparam logic [6:0] GLOBAL_LAST = 7'h3F;
   localparam logic [6:0] LAST_ADDR = 7'h7F;
   localparam logic [4:0] GLOBAL_PAGE = 5'h00;
   localparam logic [15:0] PAGE_RESET = 16'h0000;
   localparam logic [2:0] TARGET_UPPER = 3'h5;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic PROTO_I2C = 1'b1;

   // ==========================================================
   // Strap decode codes
   localparam logic [1:0] STRAP_LOW = 2'h0;
   localparam logic [1:0] STRAP_HIGH = 2'h1;
   localparam logic [1:0] STRAP_SDA = 2'h2;
   localparam logic [1:0] STRAP_SCL = 2'h3;

   // ==========================================================
   // Input lines and buffering
   localparam int unsigned NUM_LINES = 4;
   localparam int unsigned LINE_SCL = 0;
   localparam int unsigned LINE_SDA = 1;
   localparam logic [3:0] LINE_RESET = 4'hF;
   localparam int unsigned FIFO_DEPTH = 4;

   // ==========================================================
   // Types
   typedef struct packed {
      logic global_win;
      logic [4:0] page;
      logic [6:0] offset;
   } reg_loc_t;

   typedef struct packed {
      reg_loc_t loc;
      logic [15:0] data;
   } wr_word_t;

   typedef enum logic [1:0] {
      WIDX_REG = 2'h0,
      WIDX_HI = 2'h1,
      WIDX_LO = 2'h2
   } wr_idx_t;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ADDR = 8'h02,
      ST_ADDR_ACK = 8'h04,
      ST_RX = 8'h08,
      ST_RX_ACK = 8'h10,
      ST_TX = 8'h20,
      ST_TX_ACK = 8'h40,
      ST_IGNORE = 8'h80
   } bus_state_t;

endpackage

/* File: bench/paged_port_checker.sv */
`timescale 1ns/1ps
module port_checker #(
   parameter int unsigned TIMEOUT_CYCLES = 1000
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Watched ports
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic wr_valid_o,
   input wire logic wr_ready_i,
   input wire i2c_target_pkg::wr_word_t wr_word_o,
   input wire i2c_target_pkg::reg_loc_t rd_loc_o,
   input wire logic i2c_mode_o,
   input wire logic [15:0] page_o,
   input wire logic busy_o
);
   // ==========
   // Length of the current pull on SDA
   int unsigned oe_cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i || !sda_oe_o) begin
         oe_cnt <= 0;
      end else begin
         oe_cnt <= oe_cnt + 1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_idle2;
      !busy_o ##1 !busy_o;
   endsequence
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !sda_oe_o && !i2c_mode_o && page_o == 16'h0000)
      else $error("outputs not cleared by reset");
   a_open_drain: assert property (sda_o == 1'b0)
      else $error("sda driven high");
   a_mode_fixed: assert property (i2c_mode_o |=> i2c_mode_o)
      else $error("protocol choice changed");
   a_page_hold: assert property (s_idle2 |-> $stable(page_o))
      else $error("page changed while idle");
   a_idle_release: assert property (s_idle2 |-> !sda_oe_o)
      else $error("sda pulled while idle");
   a_fifo_hold: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_word_o))
      else $error("stalled word lost");
   a_pull_bounded: assert property (oe_cnt <= TIMEOUT_CYCLES + 16)
      else $error("sda held past timeout");
   a_word_not_page: assert property (wr_valid_o |-> wr_word_o.loc.offset != 7'h01)
      else $error("page write sent to buffer");
   a_global_win: assert property (wr_valid_o |-> wr_word_o.loc.global_win == (wr_word_o.loc.offset <= 7'h3F))
      else $error("global window flag wrong");
   a_global_page: assert property (rd_loc_o.global_win |-> rd_loc_o.page == 5'h00)
      else $error("global read carries page");
endmodule

/* File: bench/i2c_ctl.sv */
`timescale 1ns/1ps
module i2c_ctl (
   // Bus lines
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   localparam time Q = 50ns;
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Long low phase lets the target drop its acknowledge before SCL rises
   task automatic start();
      sda_low_o = 1'b0;
      #(3*Q) scl_o = 1'b1;
      #(2*Q) sda_low_o = 1'b1;
      #(2*Q) scl_o = 1'b0;
   endtask
   // Low phase of 150 ns outlasts the target's sync, filter and register lag
   task automatic bit_io(input logic b, output logic r);
      #(Q) sda_low_o = !b;
      #(2*Q) scl_o = 1'b1;
      #(Q/2) r = sda_i;
      #(Q/2) scl_o = 1'b0;
   endtask
   task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(a, k);
   endtask
   task automatic stop();
      #(Q) sda_low_o = 1'b1;
      #(Q) scl_o = 1'b1;
      #(2*Q) sda_low_o = 1'b0;
      #(4*Q);
   endtask
endmodule

/* File: bench/paged_i2c_target_port_tb_top.sv */
`timescale 1ns/1ps
module paged_i2c_target_port_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr_ready = 1'b0;
   logic proto = 1'b1;
   logic [1:0] hi_c = 2'h1;
   logic [1:0] lo_c = 2'h2;
   logic scl, low, oe, mode, busy, wr_valid, ak;
   logic [7:0] q;
   logic [15:0] page;
   i2c_target_pkg::wr_word_t wr_word;
   i2c_target_pkg::reg_loc_t rd_loc;
   int error_cnt = 0;
   int checks = 0;
   wire logic sda = !(low || oe);
   wire logic [6:0] dev = {3'h5, hi_c, lo_c};
   wire logic s_hi = hi_c == 2'h0 ? 1'b0 : hi_c == 2'h1 ? 1'b1 : hi_c == 2'h2 ? sda : scl;
   wire logic s_lo = lo_c == 2'h0 ? 1'b0 : lo_c == 2'h1 ? 1'b1 : lo_c == 2'h2 ? sda : scl;
   always #12.5 clk_i = !clk_i;
   paged_i2c_target_port #(.TIMEOUT_CYCLES(2000)) paged_i2c_target_port_i (.clk_i(clk_i), .rst_i(rst_i),
      .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe), .addr_strap_low_i(s_lo), .addr_strap_high_i(s_hi),
      .proto_sel_i(proto), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_word_o(wr_word),
      .rd_loc_o(rd_loc), .rd_data_i({3'h5, rd_loc}), .i2c_mode_o(mode), .page_o(page), .busy_o(busy));
   i2c_ctl i2c_ctl_i (.scl_o(scl), .sda_low_o(low), .sda_i(sda));
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic e);
      i2c_ctl_i.byte_io(b, 1'b1, q, ak);
      check("ack", e, ak);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (20) @(negedge clk_i);
      check("mode", 1'b1, mode);
      // Protocol strap moves after the choice is made; it must be ignored
      proto = 1'b0;
      i2c_ctl_i.start();
      send({dev, 1'b0}, 1'b0);
      send(8'h01, 1'b0);
      send(8'h00, 1'b0);
      send(8'h13, 1'b0);
      i2c_ctl_i.stop();
      check("page", 16'h0013, page);
      $display("page test done");
      i2c_ctl_i.start();
      send({dev, 1'b0}, 1'b0);
      send(8'hFE, 1'b0);
      for (int w = 0; w < 5; w++) begin
         send({4'hA, 4'(w)}, 1'b0);
         send({4'h3, 4'(w)}, w == 4);
      end
      i2c_ctl_i.stop();
      // Ready stays up across the drain; one pop per rising edge
      wr_ready = 1'b1;
      for (int w = 0; w < 4; w++) begin
         check("valid", 1'b1, wr_valid);
         check("word", {1'b0, 5'h13, w == 0 ? 7'h7E : 7'h7F, 4'hA, 4'(w), 4'h3, 4'(w)}, wr_word);
         @(posedge clk_i);
         @(negedge clk_i);
      end
      wr_ready = 1'b0;
      check("valid", 1'b0, wr_valid);
      $display("block test done");
      i2c_ctl_i.start();
      send({dev, 1'b0}, 1'b0);
      send(8'h05, 1'b0);
      for (int t = 0; t < 2; t++) begin
         i2c_ctl_i.start();
         send({dev, 1'b1}, 1'b0);
         i2c_ctl_i.byte_io(8'hFF, 1'b0, q, ak);
         check("rd_hi", 8'hB0, q);
         i2c_ctl_i.byte_io(8'hFF, 1'b1, q, ak);
         check("rd_lo", 8'h05, q);
      end
      i2c_ctl_i.stop();
      $display("read test done");
      hi_c = 2'h0;
      lo_c = 2'h3;
      i2c_ctl_i.start();
      send(8'hAC, 1'b1);
      send(8'h05, 1'b1);
      i2c_ctl_i.start();
      send({dev, 1'b0}, 1'b0);
      for (int i = 0; i < 8; i++) begin
         i2c_ctl_i.bit_io(1'b0, ak);
      end
      repeat (8) @(negedge clk_i);
      check("oe", 1'b1, oe);
      repeat (2100) @(negedge clk_i);
      check("oe", 1'b0, oe);
      check("busy", 1'b0, busy);
      i2c_ctl_i.stop();
      i2c_ctl_i.start();
      send({dev, 1'b0}, 1'b0);
      i2c_ctl_i.stop();
      check("mode", 1'b1, mode);
      $display("strap test done");
      test_done();
   end
   initial begin
      #1ms;
      error_cnt++;
      test_done();
   end
endmodule
bind paged_i2c_target_port port_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) port_checker_i (.clk_i(clk_i),
   .rst_i(rst_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
   .wr_word_o(wr_word_o), .rd_loc_o(rd_loc_o), .i2c_mode_o(i2c_mode_o), .page_o(page_o), .busy_o(busy_o));
